// *** rtl/can_irq_filter_fifo_status.sv ***
// Purpose: can interrupt code, filter control and fifo interrupt status
// Assumes: apb slave, protocol engine and fifos on ref_clk_i
// Notes: zero-wait apb; unmapped reads return zero with pslverr
`timescale 1ns/1ps
`default_nettype none
module can_irq_filter_fifo_status
  import can_irq_pkg::*;
#(
  parameter int fifos = num_fifos
)
(
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic filter_hit_valid_i,
  input wire logic [3:0] filter_hit_i,
  input wire logic [num_events-1:0] event_i,
  input wire logic [fifos-1:0] fifo_direction_transmit_i,
  input wire logic [fifos-1:0] fifo_empty_i,
  input wire logic [fifos-1:0] fifo_half_i,
  input wire logic [fifos-1:0] fifo_full_i,
  input wire logic [fifos-1:0] fifo_overflow_i,
  output logic [num_filters-1:0] filter_enable_o,
  output logic [2*num_filters-1:0] filter_mask_select_o,
  output logic [5*num_filters-1:0] filter_destination_fifo_o,
  output logic [6:0] interrupt_code_o,
  output logic any_pending_o
);
  logic wr;
  logic rd;
  logic [31:0] filter_r;
  logic [31:0] filter_nxt;
  logic [4:0] hit_r;
  logic [4:0] hit_nxt;
  logic [num_events-1:0] ev_r;
  logic [num_events-1:0] ev_nxt;
  logic [6:0] code_r;
  logic [6:0] code_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic err_r;
  logic err_nxt;
  logic [fifos-1:0] fifo_status;
  logic [31:0] slice_rdata [fifos];
  logic rx_overflow_summary_flag;
  logic mapped;
  logic fifo_any;
  logic [6:0] fifo_code;

  assign wr = psel_i & penable_i & pwrite_i;
  assign rd = psel_i & ~penable_i & ~pwrite_i;

  genvar g;
  generate
    for (g = 0; g < fifos; g++)
    begin : gen_fifo
      fifo_int_if bus_if ();
      assign bus_if.wr_en = wr && (paddr_i == 12'(off_fifo_int_base + g * fifo_int_stride));
      assign bus_if.wdata = pwdata_i;
      assign bus_if.direction_transmit = fifo_direction_transmit_i[g];
      assign bus_if.empty = fifo_empty_i[g];
      assign bus_if.half = fifo_half_i[g];
      assign bus_if.full = fifo_full_i[g];
      assign bus_if.overflow_event = fifo_overflow_i[g];
      assign fifo_status[g] = bus_if.irq;
      assign slice_rdata[g] = bus_if.rdata;
      fifo_int_slice u_slice (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .port(bus_if.top)
      );
    end
  endgenerate

  // overflow summary from the sticky per-fifo overflow bits
  always_comb
  begin
    rx_overflow_summary_flag = 1'b0;
    for (int i = 0; i < fifos; i++)
    begin
      rx_overflow_summary_flag = rx_overflow_summary_flag |
        slice_rdata[i][rx_overflow_if_pos];
    end
  end

  // filter control: all fields but the enable bit of an enabled filter are frozen
  always_comb
  begin
    filter_nxt = filter_r;
    if (wr && paddr_i == off_filter_control_0)
    begin
      for (int f = 0; f < num_filters; f++)
      begin
        if (!filter_r[f*filter_field_w + filter_en_pos])
        begin
          filter_nxt[f*filter_field_w +: filter_field_w] =
            pwdata_i[f*filter_field_w +: filter_field_w];
        end
        else
        begin
          filter_nxt[f*filter_field_w + filter_en_pos] =
            pwdata_i[f*filter_field_w + filter_en_pos];
        end
      end
    end
  end

  // events: sticky, write 0 clears, set wins
  always_comb
  begin
    ev_nxt = ev_r;
    if (wr && paddr_i == off_event_control)
    begin
      ev_nxt = ev_r & pwdata_i[num_events-1:0];
    end
    ev_nxt = ev_nxt | event_i;
  end

  // filter hit capture
  always_comb
  begin
    hit_nxt = hit_r;
    if (filter_hit_valid_i)
    begin
      hit_nxt = {1'b0, filter_hit_i};
    end
  end

  // lowest-numbered fifo with its status bit set
  always_comb
  begin
    fifo_any = 1'b0;
    fifo_code = 7'h00;
    for (int i = fifos - 1; i >= 0; i--)
    begin
      if (fifo_status[i])
      begin
        fifo_any = 1'b1;
        fifo_code = 7'(i);
      end
    end
  end

  // code priority: lowest fifo first, then system events
  always_comb
  begin
    code_nxt = code_none;
    if (ev_r[ev_invalid_message_pos])
    begin
      code_nxt = code_invalid_message;
    end
    if (ev_r[ev_mode_change_pos])
    begin
      code_nxt = code_mode_change;
    end
    if (ev_r[ev_timestamp_pos])
    begin
      code_nxt = code_timestamp;
    end
    if (ev_r[ev_bandwidth_error_pos])
    begin
      code_nxt = code_bandwidth_error;
    end
    if (ev_r[ev_address_error_pos])
    begin
      code_nxt = code_address_error;
    end
    if (rx_overflow_summary_flag)
    begin
      code_nxt = code_rx_overflow;
    end
    if (ev_r[ev_wakeup_pos])
    begin
      code_nxt = code_wakeup;
    end
    if (ev_r[ev_bus_error_pos])
    begin
      code_nxt = code_bus_error;
    end
    if (fifo_any)
    begin
      code_nxt = fifo_code;
    end
  end

  // address decode for the error response; the read mux decodes on its own
  always_comb
  begin
    mapped = 1'b0;
    if (paddr_i == off_interrupt_code || paddr_i == off_filter_control_0)
    begin
      mapped = 1'b1;
    end
    if (paddr_i == off_fifo_status_summary || paddr_i == off_event_control)
    begin
      mapped = 1'b1;
    end
    for (int i = 0; i < fifos; i++)
    begin
      if (paddr_i == 12'(off_fifo_int_base + i * fifo_int_stride))
      begin
        mapped = 1'b1;
      end
    end
  end

  // apb read data, sampled in setup so it stands in access phase
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    err_nxt = psel_i & ~penable_i & ~mapped;
    if (rd)
    begin
      if (paddr_i == off_interrupt_code)
      begin
        rdata_nxt[filter_hit_lsb +: 5] = hit_r;
        rdata_nxt[6:0] = code_r;
      end
      else if (paddr_i == off_filter_control_0)
      begin
        rdata_nxt = filter_r;
      end
      else if (paddr_i == off_fifo_status_summary)
      begin
        rdata_nxt = 32'(fifo_status);
      end
      else if (paddr_i == off_event_control)
      begin
        rdata_nxt = 32'(ev_r);
      end
      else
      begin
        for (int i = 0; i < fifos; i++)
        begin
          if (paddr_i == 12'(off_fifo_int_base + i * fifo_int_stride))
          begin
            rdata_nxt = slice_rdata[i];
          end
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      filter_r <= filter_control_reset;
      ev_r <= event_control_reset[num_events-1:0];
      hit_r <= 5'h00;
      code_r <= code_none;
      rdata_r <= 32'h0000_0000;
      err_r <= 1'b0;
    end
    else
    begin
      filter_r <= filter_nxt;
      ev_r <= ev_nxt;
      hit_r <= hit_nxt;
      code_r <= code_nxt;
      rdata_r <= rdata_nxt;
      err_r <= err_nxt;
    end
  end

  always_comb
  begin
    for (int f = 0; f < num_filters; f++)
    begin
      filter_enable_o[f] = filter_r[f*filter_field_w + filter_en_pos];
      filter_mask_select_o[2*f +: 2] = filter_r[f*filter_field_w + filter_msel_lsb +: 2];
      filter_destination_fifo_o[5*f +: 5] = filter_r[f*filter_field_w +: 5];
    end
  end

  assign prdata_o = rdata_r;
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i & penable_i & err_r;
  assign interrupt_code_o = code_r;
  assign any_pending_o = (code_r != code_none);
endmodule
`default_nettype wire

// *** rtl/can_irq_pkg.sv ***
// Purpose: shared constants for the can interrupt/filter/fifo status block
// Assumes: apb slave with 32-bit data, one aligned word per register
// Notes: offsets are byte addresses
package can_irq_pkg;
  localparam int num_fifos = 16;
  localparam int num_filters = 4;
  localparam logic [11:0] off_interrupt_code = 12'h000;
  localparam logic [11:0] off_filter_control_0 = 12'h010;
  localparam logic [11:0] off_fifo_status_summary = 12'h020;
  localparam logic [11:0] off_event_control = 12'h030;
  localparam logic [11:0] off_fifo_int_base = 12'h100;
  localparam logic [11:0] fifo_int_stride = 12'h010;
  localparam int filter_hit_lsb = 8;
  localparam int filter_en_pos = 7;
  localparam int filter_msel_lsb = 5;
  localparam int filter_dest_lsb = 0;
  localparam int filter_field_w = 8;
  localparam int tx_not_full_ie_pos = 26;
  localparam int tx_half_ie_pos = 25;
  localparam int tx_empty_ie_pos = 24;
  localparam int rx_overflow_ie_pos = 19;
  localparam int rx_full_ie_pos = 18;
  localparam int rx_half_ie_pos = 17;
  localparam int rx_not_empty_ie_pos = 16;
  localparam int tx_not_full_if_pos = 10;
  localparam int tx_half_if_pos = 9;
  localparam int tx_empty_if_pos = 8;
  localparam int rx_overflow_if_pos = 3;
  localparam int rx_full_if_pos = 2;
  localparam int rx_half_if_pos = 1;
  localparam int rx_not_empty_if_pos = 0;
  localparam logic [31:0] filter_control_reset = 32'h0000_0000;
  localparam logic [31:0] fifo_int_reset = 32'h0000_0000;
  localparam logic [31:0] event_control_reset = 32'h0000_0000;
  localparam logic [6:0] code_none = 7'h40;
  localparam logic [6:0] code_bus_error = 7'h41;
  localparam logic [6:0] code_wakeup = 7'h42;
  localparam logic [6:0] code_rx_overflow = 7'h43;
  localparam logic [6:0] code_address_error = 7'h44;
  localparam logic [6:0] code_bandwidth_error = 7'h45;
  localparam logic [6:0] code_timestamp = 7'h46;
  localparam logic [6:0] code_mode_change = 7'h47;
  localparam logic [6:0] code_invalid_message = 7'h48;
  // event_control register: sticky event flags, write 0 to clear
  localparam int ev_bus_error_pos = 0;
  localparam int ev_wakeup_pos = 1;
  localparam int ev_address_error_pos = 2;
  localparam int ev_bandwidth_error_pos = 3;
  localparam int ev_timestamp_pos = 4;
  localparam int ev_mode_change_pos = 5;
  localparam int ev_invalid_message_pos = 6;
  localparam int num_events = 7;
endpackage

// *** rtl/fifo_int_if.sv ***
// Purpose: carries one fifo interrupt register between top and slice
// Assumes: same clock on both sides
// Notes: one instance per fifo
`timescale 1ns/1ps
`default_nettype none
interface fifo_int_if;
  logic wr_en;
  logic [31:0] wdata;
  logic direction_transmit;
  logic empty;
  logic half;
  logic full;
  logic overflow_event;
  logic [31:0] rdata;
  logic irq;
  modport top (output wr_en, output wdata, output direction_transmit, output empty,
    output half, output full, output overflow_event, input rdata, input irq);
  modport slice (input wr_en, input wdata, input direction_transmit, input empty,
    input half, input full, input overflow_event, output rdata, output irq);
endinterface
`default_nettype wire

// *** rtl/fifo_int_slice.sv ***
// Purpose: one fifo interrupt register: enables, fill flags, overflow flag
// Assumes: fill inputs from logic on the same clock
// Notes: set of overflow wins over a software clear
`timescale 1ns/1ps
`default_nettype none
module fifo_int_slice
  import can_irq_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic srst_i,
  fifo_int_if.slice port
);
  logic [6:0] enables_r;
  logic [6:0] enables_nxt;
  logic overflow_r;
  logic overflow_nxt;
  logic tx_not_full;
  logic tx_half;
  logic tx_empty;
  logic rx_full;
  logic rx_half;
  logic rx_not_empty;
  logic [31:0] rd;

  always_comb
  begin
    enables_nxt = enables_r;
    overflow_nxt = overflow_r;
    if (port.wr_en)
    begin
      enables_nxt = {port.wdata[tx_not_full_ie_pos], port.wdata[tx_half_ie_pos],
        port.wdata[tx_empty_ie_pos], port.wdata[rx_overflow_ie_pos],
        port.wdata[rx_full_ie_pos], port.wdata[rx_half_ie_pos],
        port.wdata[rx_not_empty_ie_pos]};
      if (!port.wdata[rx_overflow_if_pos])
      begin
        overflow_nxt = 1'b0;
      end
    end
    if (port.overflow_event)
    begin
      overflow_nxt = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      enables_r <= fifo_int_reset[6:0];
      overflow_r <= 1'b0;
    end
    else
    begin
      enables_r <= enables_nxt;
      overflow_r <= overflow_nxt;
    end
  end

  // live fill flags, gated by direction
  assign tx_not_full = port.direction_transmit & ~port.full;
  assign tx_half = port.direction_transmit & port.half;
  assign tx_empty = port.direction_transmit & port.empty;
  assign rx_full = ~port.direction_transmit & port.full;
  assign rx_half = ~port.direction_transmit & port.half;
  assign rx_not_empty = ~port.direction_transmit & ~port.empty;

  always_comb
  begin
    rd = 32'h0000_0000;
    rd[tx_not_full_ie_pos] = enables_r[6];
    rd[tx_half_ie_pos] = enables_r[5];
    rd[tx_empty_ie_pos] = enables_r[4];
    rd[rx_overflow_ie_pos] = enables_r[3];
    rd[rx_full_ie_pos] = enables_r[2];
    rd[rx_half_ie_pos] = enables_r[1];
    rd[rx_not_empty_ie_pos] = enables_r[0];
    rd[tx_not_full_if_pos] = tx_not_full;
    rd[tx_half_if_pos] = tx_half;
    rd[tx_empty_if_pos] = tx_empty;
    rd[rx_overflow_if_pos] = overflow_r;
    rd[rx_full_if_pos] = rx_full;
    rd[rx_half_if_pos] = rx_half;
    rd[rx_not_empty_if_pos] = rx_not_empty;
  end

  assign port.rdata = rd;
  assign port.irq = |({tx_not_full, tx_half, tx_empty, overflow_r, rx_full, rx_half,
    rx_not_empty} & enables_r);
endmodule
`default_nettype wire

// *** tb/can_engine_model.sv ***
// Purpose: protocol engine and fifo fill side of the can status block
// Assumes: driven right after rising edges of ref_clk_i
// Notes: fill levels 0 empty, 1 partly, 2 half, 3 full
`timescale 1ns/1ps
`default_nettype none
module can_engine_model
  import can_irq_pkg::*;
(
  input wire logic ref_clk_i,
  output logic hit_valid_o,
  output logic [3:0] hit_o,
  output logic [num_events-1:0] event_o,
  output logic [num_fifos-1:0] dir_tx_o,
  output logic [num_fifos-1:0] empty_o,
  output logic [num_fifos-1:0] half_o,
  output logic [num_fifos-1:0] full_o,
  output logic [num_fifos-1:0] ovfl_o
);
  initial
  begin
    {hit_valid_o, hit_o, event_o, dir_tx_o, half_o, full_o, ovfl_o} = '0;
    empty_o = '1;
  end
  // kind 0 event, 1 filter hit, 2 fifo overflow; one-cycle pulses
  task automatic pulse(input int kind, input int k);
    @(posedge ref_clk_i);
    if (kind == 0) event_o[k] <= 1'b1;
    if (kind == 1) {hit_valid_o, hit_o} <= {1'b1, 4'(k)};
    if (kind == 2 && full_o[k]) ovfl_o[k] <= 1'b1;
    @(posedge ref_clk_i);
    {hit_valid_o, event_o, ovfl_o} <= '0;
  endtask
  task automatic set_fill(input int n, input logic tx, input int lvl);
    @(posedge ref_clk_i);
    dir_tx_o[n] <= tx;
    empty_o[n] <= (lvl == 0);
    half_o[n] <= (lvl >= 2);
    full_o[n] <= (lvl == 3);
  endtask
endmodule
`default_nettype wire

// *** tb/can_irq_asserts.sv ***
// Purpose: port-level checks of the can interrupt and filter block
// Assumes: one clock domain, synchronous active-high reset
// Notes: bound to the top module below
`timescale 1ns/1ps
`default_nettype none
module can_irq_asserts
  import can_irq_pkg::*;
#(
  parameter int fifos = num_fifos
)
(
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic [num_events-1:0] event_i,
  input wire logic [fifos-1:0] fifo_direction_transmit_i,
  input wire logic [fifos-1:0] fifo_full_i,
  input wire logic [fifos-1:0] fifo_overflow_i,
  input wire logic [num_filters-1:0] filter_enable_o,
  input wire logic [2*num_filters-1:0] filter_mask_select_o,
  input wire logic [5*num_filters-1:0] filter_destination_fifo_o,
  input wire logic [6:0] interrupt_code_o,
  input wire logic any_pending_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  property p_pending_code;
    any_pending_o == (interrupt_code_o != code_none);
  endproperty
  a_pending_code: assert property (p_pending_code) else $error("pending flag off");
  property p_reset_none;
    $fell(srst_i) |-> interrupt_code_o == code_none;
  endproperty
  a_reset_none: assert property (p_reset_none) else $error("code after reset");
  property p_event_code;
    event_i != '0 |-> ##2 any_pending_o;
  endproperty
  a_event_code: assert property (p_event_code) else $error("event gave no code");
  property p_ovfl_code;
    fifo_overflow_i != '0 |-> ##2 any_pending_o;
  endproperty
  a_ovfl_code: assert property (p_ovfl_code) else $error("overflow gave no code");
  property p_code_range;
    interrupt_code_o < 7'h10 || (interrupt_code_o >= code_none && interrupt_code_o <= 7'h48);
  endproperty
  a_code_range: assert property (p_code_range) else $error("reserved code shown");
  property p_filter_locked;
    filter_enable_o[3] && $past(filter_enable_o[3]) |->
      $stable(filter_mask_select_o[7:6]) && $stable(filter_destination_fifo_o[19:15]);
  endproperty
  a_filter_locked: assert property (p_filter_locked) else $error("locked filter changed");
  property p_code_readback;
    psel_i && !penable_i && !pwrite_i && paddr_i == off_interrupt_code |=>
      prdata_o[6:0] == $past(interrupt_code_o) && prdata_o[31:12] == '0 && !prdata_o[7];
  endproperty
  a_code_readback: assert property (p_code_readback) else $error("code read wrong");
  property p_tx_flag;
    psel_i && !penable_i && !pwrite_i && paddr_i == off_fifo_int_base |=>
      prdata_o[10] == ($past(fifo_direction_transmit_i[0]) && !$past(fifo_full_i[0]));
  endproperty
  a_tx_flag: assert property (p_tx_flag) else $error("tx not full flag wrong");
endmodule
bind can_irq_filter_fifo_status can_irq_asserts #(.fifos(fifos)) i_asserts (
  .ref_clk_i(ref_clk_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .event_i(event_i),
  .fifo_direction_transmit_i(fifo_direction_transmit_i), .fifo_full_i(fifo_full_i),
  .fifo_overflow_i(fifo_overflow_i), .filter_enable_o(filter_enable_o),
  .filter_mask_select_o(filter_mask_select_o), .interrupt_code_o(interrupt_code_o),
  .filter_destination_fifo_o(filter_destination_fifo_o), .any_pending_o(any_pending_o));
`default_nettype wire

// *** tb/can_irq_filter_fifo_status_bench.sv ***
// Purpose: self-checking bench of the can interrupt, filter and fifo block
// Assumes: apb master in this module, engine side in the model
// Notes: event codes are table rows, the rest hand-written
`timescale 1ns/1ps
`default_nettype none
module can_irq_filter_fifo_status_bench
  import can_irq_pkg::*;
;
  typedef struct {int ev; logic [6:0] code;} row_t;
  logic ref_clk_i = 1'b0, srst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [11:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0, prdata_o, rd_q;
  logic pready_o, pslverr_o, rd_e, fh_v, any_pending_o;
  logic [3:0] fh, filter_enable_o;
  logic [num_events-1:0] ev;
  logic [num_fifos-1:0] dtx, emp, hlf, ful, ovf;
  logic [7:0] filter_mask_select_o;
  logic [19:0] filter_destination_fifo_o;
  logic [6:0] interrupt_code_o;
  int err_total = 0, checks_done = 0;
  row_t rows [num_events] = '{'{ev_bus_error_pos, code_bus_error},
    '{ev_wakeup_pos, code_wakeup}, '{ev_address_error_pos, code_address_error},
    '{ev_bandwidth_error_pos, code_bandwidth_error}, '{ev_timestamp_pos, code_timestamp},
    '{ev_mode_change_pos, code_mode_change}, '{ev_invalid_message_pos, code_invalid_message}};
  always #4 ref_clk_i = ~ref_clk_i;
  can_irq_filter_fifo_status i_dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .filter_hit_valid_i(fh_v), .filter_hit_i(fh), .event_i(ev),
    .fifo_direction_transmit_i(dtx), .fifo_empty_i(emp), .fifo_half_i(hlf),
    .fifo_full_i(ful), .fifo_overflow_i(ovf), .filter_enable_o(filter_enable_o),
    .filter_mask_select_o(filter_mask_select_o), .interrupt_code_o(interrupt_code_o),
    .filter_destination_fifo_o(filter_destination_fifo_o), .any_pending_o(any_pending_o));
  can_engine_model i_model (.ref_clk_i(ref_clk_i), .hit_valid_o(fh_v), .hit_o(fh),
    .event_o(ev), .dir_tx_o(dtx), .empty_o(emp), .half_o(hlf), .full_o(ful), .ovfl_o(ovf));
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, w, a, d};
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    @(posedge ref_clk_i);
    while (pready_o !== 1'b1 && n < 50)
    begin
      @(posedge ref_clk_i);
      n++;
    end
    if (n == 50) err_total++;
    rd_q = prdata_o;
    rd_e = pslverr_o;
    {psel_i, penable_i} <= 2'b00;
    @(negedge ref_clk_i);
  endtask
  task automatic settle();
    repeat (2) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge ref_clk_i);
    err_total++;
    end_sim();
  end
  initial
  begin
    repeat (10) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    @(negedge ref_clk_i);
    chk("code at reset", interrupt_code_o, code_none);
    apb(0, off_filter_control_0, 0);
    chk("filter reset", rd_q, filter_control_reset);
    apb(0, off_fifo_int_base, 0);
    chk("fifo int reset", rd_q, fifo_int_reset);
    $display("reset test done");
    foreach (rows[i])
    begin
      i_model.pulse(0, rows[i].ev);
      apb(0, off_interrupt_code, 0);
      chk("event code", rd_q[6:0], rows[i].code);
      apb(1, off_event_control, 0);
      settle();
      chk("cleared code", interrupt_code_o, code_none);
    end
    $display("event table done");
    for (int m = 0; m < 4; m++)
    begin
      apb(1, off_filter_control_0, {8'h00, 1'b0, 2'(m), 5'(m), 16'h0000});
      chk("mask select", filter_mask_select_o[5:4], m);
      chk("destination", filter_destination_fifo_o[14:10], m);
    end
    apb(1, off_filter_control_0, 32'hef00_0000);
    chk("filter enables", filter_enable_o, 4'b1000);
    chk("mask 3", filter_mask_select_o[7:6], 2'b11);
    chk("dest 3", filter_destination_fifo_o[19:15], 5'h0f);
    apb(1, off_filter_control_0, 32'h8080_0000);
    apb(0, off_filter_control_0, 0);
    chk("locked filter", rd_q, 32'hef80_0000);
    apb(1, off_filter_control_0, 32'h0000_0000);
    chk("filter off", filter_enable_o, 4'b0000);
    $display("filter test done");
    i_model.pulse(1, 15);
    apb(0, off_interrupt_code, 0);
    chk("filter hit", rd_q[12:8], 5'h0f);
    $display("filter hit test done");
    i_model.set_fill(0, 1'b0, 1);
    apb(1, off_fifo_int_base, 32'h0001_0000);
    settle();
    chk("fifo 0 code", interrupt_code_o, 7'h00);
    apb(0, off_fifo_status_summary, 0);
    chk("status summary", rd_q, 32'h0000_0001);
    apb(1, off_fifo_int_base, 32'hffff_ffff);
    apb(0, off_fifo_int_base, 0);
    chk("fifo 0 rx", rd_q, 32'h070f_0001);
    i_model.set_fill(0, 1'b0, 0);
    settle();
    chk("fifo 0 idle", interrupt_code_o, code_none);
    i_model.set_fill(0, 1'b1, 1);
    apb(0, off_fifo_int_base, 0);
    chk("fifo 0 tx", rd_q, 32'h070f_0400);
    i_model.set_fill(0, 1'b1, 0);
    apb(0, off_fifo_int_base, 0);
    chk("fifo 0 tx empty", rd_q, 32'h070f_0500);
    i_model.set_fill(0, 1'b1, 3);
    apb(0, off_fifo_int_base, 0);
    chk("fifo 0 tx full", rd_q, 32'h070f_0200);
    chk("fifo 0 half code", interrupt_code_o, 7'h00);
    apb(1, off_fifo_int_base, 0);
    i_model.set_fill(0, 1'b0, 0);
    $display("fifo flag test done");
    i_model.set_fill(3, 1'b0, 3);
    i_model.pulse(2, 3);
    apb(0, off_fifo_int_base + 12'h030, 0);
    chk("overflow set", rd_q, 32'h0000_000f);
    chk("overflow code", interrupt_code_o, code_rx_overflow);
    apb(1, off_fifo_int_base + 12'h030, 0);
    apb(0, off_fifo_int_base + 12'h030, 0);
    chk("overflow cleared", rd_q, 32'h0000_0007);
    settle();
    chk("code after clear", interrupt_code_o, code_none);
    apb(0, 12'h004, 0);
    chk("unmapped error", rd_e, 1'b1);
    chk("unmapped data", rd_q, 0);
    $display("overflow and unmapped test done");
    i_model.pulse(0, ev_wakeup_pos);
    apb(1, off_filter_control_0, 32'h0000_0080);
    chk("code before reset", interrupt_code_o, code_wakeup);
    @(posedge ref_clk_i);
    srst_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    @(negedge ref_clk_i);
    chk("code after reset", interrupt_code_o, code_none);
    chk("filter after reset", filter_enable_o, 4'b0000);
    apb(0, off_event_control, 0);
    chk("events after reset", rd_q, 0);
    $display("mid-run reset test done");
    end_sim();
  end
endmodule
`default_nettype wire
